// ### ipv_defines.vh
// Purpose: Constants for the interrupt priority and vectoring block
// Assumes: Word addressed program space, 24-bit vector addresses
// Notes: Vector numbers and levels are fixed by the vector map
`ifndef IPV_DEFINES_VH
`define IPV_DEFINES_VH
`define IPV_NUM_VEC 82
`define IPV_VEC_W 7
`define IPV_LVL_W 2
`define IPV_ADDR_W 24
`define IPV_REACH_W 19
`define IPV_VBA_W 16
`define IPV_VBA_SHIFT 7
`define IPV_VBA_RESET 16'h0200
`define IPV_VBA_EXT_NARROW 16'h0000
`define IPV_LVL_FIXED3 2'h3
`define IPV_LVL_SWI2 2'h2
`define IPV_LVL_SWI1 2'h1
`define IPV_LVL_SWI0 2'h0
`define IPV_LVL_MAX_PERIPH 2'h2
`define IPV_LVL_MIN_DEBUG 2'h1
`define IPV_VEC_NONE 7'h00
`define IPV_VEC_COREHI_LO 2
`define IPV_VEC_COREHI_HI 5
`define IPV_VEC_DEBUG_LO 6
`define IPV_VEC_DEBUG_HI 11
`define IPV_VEC_SWI2 14
`define IPV_VEC_SWI1 15
`define IPV_VEC_SWI0 16
`define IPV_VEC_SWI_LP 81
`define IPV_RESERVED_MASK 82'h0_0000_0000_0000_0000_0000
`endif

// ### ipv_level_map.v
// Purpose: Effective level and validity of one vector slot
// Assumes: Programmed level arrives raw from software
// Notes: Reserved slots never yield a candidate
`timescale 1ns/1ps
`include "ipv_defines.vh"
module ipv_level_map #(
	parameter VEC = 2
) (
	input wire pend_i,
	input wire enable_i,
	input wire [`IPV_LVL_W-1:0] prog_lvl_i,
	input wire [`IPV_LVL_W-1:0] mask_lvl_i,
	output reg valid_o,
	output reg [`IPV_LVL_W-1:0] lvl_o
);
	reg reserved;
	always @* begin
		reserved = (VEC < 2) || (VEC == 8) || (VEC == 12) || (VEC == 13) || (VEC == 19) ||
			(VEC == 25) || (VEC == 36) || (VEC == 37) || (VEC == 44) || (VEC == 51) ||
			(VEC == 70) || (VEC > 81);
		if (VEC >= `IPV_VEC_COREHI_LO && VEC <= `IPV_VEC_COREHI_HI) begin
			lvl_o = `IPV_LVL_FIXED3;
		end else if (VEC >= `IPV_VEC_DEBUG_LO && VEC <= `IPV_VEC_DEBUG_HI) begin
			// Level 0 is not allowed for debug sources; clamp up to 1
			lvl_o = (prog_lvl_i < `IPV_LVL_MIN_DEBUG) ? `IPV_LVL_MIN_DEBUG : prog_lvl_i;
		end else if (VEC == `IPV_VEC_SWI2) begin
			lvl_o = `IPV_LVL_SWI2;
		end else if (VEC == `IPV_VEC_SWI1) begin
			lvl_o = `IPV_LVL_SWI1;
		end else if (VEC == `IPV_VEC_SWI0) begin
			lvl_o = `IPV_LVL_SWI0;
		end else if (VEC == `IPV_VEC_SWI_LP) begin
			lvl_o = `IPV_LVL_SWI0;
		end else begin
			// Level 3 is not allowed here; clamp down to 2
			lvl_o = (prog_lvl_i > `IPV_LVL_MAX_PERIPH) ? `IPV_LVL_MAX_PERIPH : prog_lvl_i;
		end
		valid_o = pend_i && enable_i && !reserved && (lvl_o >= mask_lvl_i);
	end
endmodule // ipv_level_map

// ### ipv_vec_addr.v
// Purpose: Vector entry address from base and vector number
// Assumes: Base register holds address bits above the table offset
// Notes: Entries are two words each
`timescale 1ns/1ps
`include "ipv_defines.vh"
module ipv_vec_addr (
	input wire [`IPV_VBA_W-1:0] vba_i,
	input wire [`IPV_VEC_W-1:0] vec_i,
	output wire [`IPV_ADDR_W-1:0] addr_o
);
	wire [`IPV_ADDR_W-1:0] base;
	wire [`IPV_ADDR_W-1:0] offs;
	// Base is zero-extended so the top address bit never reads past the register
	assign base = {{(`IPV_ADDR_W-`IPV_VBA_W-`IPV_VBA_SHIFT){1'b0}}, vba_i,
		{`IPV_VBA_SHIFT{1'b0}}};
	assign offs = {{(`IPV_ADDR_W-`IPV_VEC_W-1){1'b0}}, vec_i, 1'b0};
	assign addr_o = base + offs;
endmodule // ipv_vec_addr

// ### ipv_interrupt_priority_vectoring.v
// Purpose: Priority arbitration and vector address generation
// Assumes: Source requests are level signals held until serviced
// Notes: Request bit N is vector number N; the vector base register is the only software register port
`timescale 1ns/1ps
`include "ipv_defines.vh"
module ipv_interrupt_priority_vectoring #(
	parameter NUM_VEC = `IPV_NUM_VEC
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire [NUM_VEC-1:0] irq_pend_i,
	input wire [NUM_VEC-1:0] irq_enable_i,
	input wire [2*NUM_VEC-1:0] irq_level_i,
	input wire [`IPV_LVL_W-1:0] core_mask_lvl_i,
	input wire vector_base_register_we_i,
	input wire [`IPV_VBA_W-1:0] vector_base_register_wdata_i,
	input wire ext_boot_i,
	input wire narrow_bus_i,
	input wire core_ack_i,
	output wire irq_req_o,
	output reg [`IPV_VEC_W-1:0] irq_vec_o,
	output reg [`IPV_LVL_W-1:0] irq_lvl_o,
	output reg [`IPV_ADDR_W-1:0] irq_addr_o,
	output reg [`IPV_VBA_W-1:0] vector_base_register_o,
	output reg reset_overlay_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_HOLD = 1'b1;

	// Source slots; any number not listed is a hole in the table
	localparam VEC_ILLEGAL_INSTR = 2;
	localparam VEC_SOFT_INT3 = 3;
	localparam VEC_STACK_OVF = 4;
	localparam VEC_MISALIGNED = 5;
	localparam VEC_DBG_STEP = 6;
	localparam VEC_DBG_BREAK = 7;
	localparam VEC_DBG_TRACE = 9;
	localparam VEC_DBG_TX_EMPTY = 10;
	localparam VEC_DBG_RX_FULL = 11;
	localparam VEC_SOFT_INT2 = 14;
	localparam VEC_SOFT_INT1 = 15;
	localparam VEC_SOFT_INT0 = 16;
	localparam VEC_EXT_REQ_A = 17;
	localparam VEC_EXT_REQ_B = 18;
	localparam VEC_LOW_VOLT = 20;
	localparam VEC_CLOCK_LOOP = 21;
	localparam VEC_FLASH_ACC_ERR = 22;
	localparam VEC_FLASH_CMD_DONE = 23;
	localparam VEC_FLASH_BUF_EMPTY = 24;
	localparam VEC_CAN_BUS_OFF = 26;
	localparam VEC_CAN_ERROR = 27;
	localparam VEC_CAN_WAKE = 28;
	localparam VEC_CAN_MSG_BUF = 29;
	localparam VEC_PORT_F = 30;
	localparam VEC_PORT_E = 31;
	localparam VEC_PORT_D = 32;
	localparam VEC_PORT_C = 33;
	localparam VEC_PORT_B = 34;
	localparam VEC_PORT_A = 35;
	localparam VEC_SPI_U1_RX_FULL = 38;
	localparam VEC_SPI_U1_TX_EMPTY = 39;
	localparam VEC_SPI_U0_RX_FULL = 40;
	localparam VEC_SPI_U0_TX_EMPTY = 41;
	localparam VEC_SER1_TX_EMPTY = 42;
	localparam VEC_SER1_TX_IDLE = 43;
	localparam VEC_SER1_RX_ERROR = 45;
	localparam VEC_SER1_RX_FULL = 46;
	localparam VEC_QDEC1_HOME = 47;
	localparam VEC_QDEC1_INDEX = 48;
	localparam VEC_QDEC0_HOME = 49;
	localparam VEC_QDEC0_INDEX = 50;
	localparam VEC_TIMER_D0 = 52;
	localparam VEC_TIMER_D1 = 53;
	localparam VEC_TIMER_D2 = 54;
	localparam VEC_TIMER_D3 = 55;
	localparam VEC_TIMER_C0 = 56;
	localparam VEC_TIMER_C1 = 57;
	localparam VEC_TIMER_C2 = 58;
	localparam VEC_TIMER_C3 = 59;
	localparam VEC_TIMER_B0 = 60;
	localparam VEC_TIMER_B1 = 61;
	localparam VEC_TIMER_B2 = 62;
	localparam VEC_TIMER_B3 = 63;
	localparam VEC_TIMER_A0 = 64;
	localparam VEC_TIMER_A1 = 65;
	localparam VEC_TIMER_A2 = 66;
	localparam VEC_TIMER_A3 = 67;
	localparam VEC_SER0_TX_EMPTY = 68;
	localparam VEC_SER0_TX_IDLE = 69;
	localparam VEC_SER0_RX_ERROR = 71;
	localparam VEC_SER0_RX_FULL = 72;
	localparam VEC_CONV_B_DONE = 73;
	localparam VEC_CONV_A_DONE = 74;
	localparam VEC_CONV_B_LIMIT = 75;
	localparam VEC_CONV_A_LIMIT = 76;
	localparam VEC_PWM_B_RELOAD = 77;
	localparam VEC_PWM_A_RELOAD = 78;
	localparam VEC_PWM_B_FAULT = 79;
	localparam VEC_PWM_A_FAULT = 80;
	localparam VEC_SOFT_INT_LP = 81;

	wire [NUM_VEC-1:0] cand;
	wire [2*NUM_VEC-1:0] lvl_all;
	wire [`IPV_ADDR_W-1:0] addr_sel;

	reg state_q;
	reg state_d;
	reg [`IPV_VBA_W-1:0] vba_q;
	reg [`IPV_VEC_W-1:0] vec_q;
	reg [`IPV_LVL_W-1:0] lvl_q;
	reg [`IPV_ADDR_W-1:0] addr_q;
	reg req_q;
	reg found;
	reg [`IPV_VEC_W-1:0] win_vec;
	reg [`IPV_LVL_W-1:0] win_lvl;
	reg [`IPV_LVL_W-1:0] cur_lvl;
	integer i;

	genvar g;
	generate
		for (g = 0; g < NUM_VEC; g = g + 1) begin : g_slot
			ipv_level_map #(
				.VEC(g)
			) u_map (
				.pend_i(irq_pend_i[g]),
				.enable_i(irq_enable_i[g]),
				.prog_lvl_i(irq_level_i[2*g+1:2*g]),
				.mask_lvl_i(core_mask_lvl_i),
				.valid_o(cand[g]),
				.lvl_o(lvl_all[2*g+1:2*g])
			);
		end
	endgenerate

	reg [NUM_VEC-1:0] src_known;

	// Second guard on top of the slot map: only listed sources can ever win
	always @* begin
		src_known = {NUM_VEC{1'b0}};
		src_known[VEC_ILLEGAL_INSTR] = 1'b1;
		src_known[VEC_SOFT_INT3] = 1'b1;
		src_known[VEC_STACK_OVF] = 1'b1;
		src_known[VEC_MISALIGNED] = 1'b1;
		src_known[VEC_DBG_STEP] = 1'b1;
		src_known[VEC_DBG_BREAK] = 1'b1;
		src_known[VEC_DBG_TRACE] = 1'b1;
		src_known[VEC_DBG_TX_EMPTY] = 1'b1;
		src_known[VEC_DBG_RX_FULL] = 1'b1;
		src_known[VEC_SOFT_INT2] = 1'b1;
		src_known[VEC_SOFT_INT1] = 1'b1;
		src_known[VEC_SOFT_INT0] = 1'b1;
		src_known[VEC_EXT_REQ_A] = 1'b1;
		src_known[VEC_EXT_REQ_B] = 1'b1;
		src_known[VEC_LOW_VOLT] = 1'b1;
		src_known[VEC_CLOCK_LOOP] = 1'b1;
		src_known[VEC_FLASH_ACC_ERR] = 1'b1;
		src_known[VEC_FLASH_CMD_DONE] = 1'b1;
		src_known[VEC_FLASH_BUF_EMPTY] = 1'b1;
		src_known[VEC_CAN_BUS_OFF] = 1'b1;
		src_known[VEC_CAN_ERROR] = 1'b1;
		src_known[VEC_CAN_WAKE] = 1'b1;
		src_known[VEC_CAN_MSG_BUF] = 1'b1;
		src_known[VEC_PORT_F] = 1'b1;
		src_known[VEC_PORT_E] = 1'b1;
		src_known[VEC_PORT_D] = 1'b1;
		src_known[VEC_PORT_C] = 1'b1;
		src_known[VEC_PORT_B] = 1'b1;
		src_known[VEC_PORT_A] = 1'b1;
		src_known[VEC_SPI_U1_RX_FULL] = 1'b1;
		src_known[VEC_SPI_U1_TX_EMPTY] = 1'b1;
		src_known[VEC_SPI_U0_RX_FULL] = 1'b1;
		src_known[VEC_SPI_U0_TX_EMPTY] = 1'b1;
		src_known[VEC_SER1_TX_EMPTY] = 1'b1;
		src_known[VEC_SER1_TX_IDLE] = 1'b1;
		src_known[VEC_SER1_RX_ERROR] = 1'b1;
		src_known[VEC_SER1_RX_FULL] = 1'b1;
		src_known[VEC_QDEC1_HOME] = 1'b1;
		src_known[VEC_QDEC1_INDEX] = 1'b1;
		src_known[VEC_QDEC0_HOME] = 1'b1;
		src_known[VEC_QDEC0_INDEX] = 1'b1;
		src_known[VEC_TIMER_D0] = 1'b1;
		src_known[VEC_TIMER_D1] = 1'b1;
		src_known[VEC_TIMER_D2] = 1'b1;
		src_known[VEC_TIMER_D3] = 1'b1;
		src_known[VEC_TIMER_C0] = 1'b1;
		src_known[VEC_TIMER_C1] = 1'b1;
		src_known[VEC_TIMER_C2] = 1'b1;
		src_known[VEC_TIMER_C3] = 1'b1;
		src_known[VEC_TIMER_B0] = 1'b1;
		src_known[VEC_TIMER_B1] = 1'b1;
		src_known[VEC_TIMER_B2] = 1'b1;
		src_known[VEC_TIMER_B3] = 1'b1;
		src_known[VEC_TIMER_A0] = 1'b1;
		src_known[VEC_TIMER_A1] = 1'b1;
		src_known[VEC_TIMER_A2] = 1'b1;
		src_known[VEC_TIMER_A3] = 1'b1;
		src_known[VEC_SER0_TX_EMPTY] = 1'b1;
		src_known[VEC_SER0_TX_IDLE] = 1'b1;
		src_known[VEC_SER0_RX_ERROR] = 1'b1;
		src_known[VEC_SER0_RX_FULL] = 1'b1;
		src_known[VEC_CONV_B_DONE] = 1'b1;
		src_known[VEC_CONV_A_DONE] = 1'b1;
		src_known[VEC_CONV_B_LIMIT] = 1'b1;
		src_known[VEC_CONV_A_LIMIT] = 1'b1;
		src_known[VEC_PWM_B_RELOAD] = 1'b1;
		src_known[VEC_PWM_A_RELOAD] = 1'b1;
		src_known[VEC_PWM_B_FAULT] = 1'b1;
		src_known[VEC_PWM_A_FAULT] = 1'b1;
		src_known[VEC_SOFT_INT_LP] = 1'b1;
	end

	// Scan from the highest vector down so the lowest number wins a tie
	always @* begin
		found = 1'b0;
		win_vec = `IPV_VEC_NONE;
		win_lvl = 2'h0;
		cur_lvl = 2'h0;
		for (i = NUM_VEC - 1; i >= 0; i = i - 1) begin
			cur_lvl = lvl_all[2*i +: 2];
			if (cand[i] && src_known[i] && (!found || cur_lvl >= win_lvl)) begin
				found = 1'b1;
				win_vec = i[`IPV_VEC_W-1:0];
				win_lvl = cur_lvl;
			end
		end
	end

	ipv_vec_addr u_addr (
		.vba_i(vba_q),
		.vec_i(win_vec),
		.addr_o(addr_sel)
	);

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (found) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (core_ack_i) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_IDLE;
			vba_q <= `IPV_VBA_RESET;
			vec_q <= `IPV_VEC_NONE;
			lvl_q <= 2'h0;
			addr_q <= {`IPV_ADDR_W{1'b0}};
			req_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (vector_base_register_we_i) begin
				vba_q <= vector_base_register_wdata_i;
			end
			// Latch only from idle; the held choice cannot shift under the core
			if (state_q == ST_IDLE && found) begin
				vec_q <= win_vec;
				lvl_q <= win_lvl;
				addr_q <= addr_sel;
				req_q <= 1'b1;
			end else if (state_q == ST_HOLD && core_ack_i) begin
				req_q <= 1'b0;
			end
		end
	end

	assign irq_req_o = req_q;

	always @* begin
		irq_vec_o = vec_q;
		irq_lvl_o = lvl_q;
		irq_addr_o = addr_q;
		vector_base_register_o = vba_q;
		// Slots 0 and 1 then alias the boot and watchdog reset entries
		reset_overlay_o = (vba_q == `IPV_VBA_RESET) ||
			(ext_boot_i && narrow_bus_i && vba_q == `IPV_VBA_EXT_NARROW);
	end
endmodule // ipv_interrupt_priority_vectoring

// ### ipv_props.sv
// Purpose: Port assertions for the arbiter
// Assumes: Base is written only while idle
// Notes: Bound to the top module
`timescale 1ns/1ps
module ipv_props (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire core_ack_i,
	input wire [1:0] core_mask_lvl_i,
	input wire irq_req_o,
	input wire [6:0] irq_vec_o,
	input wire [1:0] irq_lvl_o,
	input wire [23:0] irq_addr_o,
	input wire [15:0] vector_base_register_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	AST_ADDR: assert property ($rose(irq_req_o) |-> irq_addr_o ==
		{1'b0, vector_base_register_o, 7'h00} + {irq_vec_o, 1'b0}) else $error("bad address");
	AST_HOLD: assert property (irq_req_o && !core_ack_i |=> irq_req_o &&
		$stable(irq_vec_o) && $stable(irq_addr_o)) else $error("vector not held");
	AST_DROP: assert property (irq_req_o && core_ack_i |=> !irq_req_o)
		else $error("req not dropped");
	AST_MASK: assert property ($rose(irq_req_o) |-> irq_lvl_o >= $past(core_mask_lvl_i))
		else $error("below mask");
	AST_RSV: assert property (irq_req_o |->
		!(irq_vec_o inside {0, 1, 8, 12, 13, 19, 25, 36, 37, 44, 51, 70})) else $error("reserved");
	AST_FIX: assert property (irq_req_o && irq_vec_o inside {[2:5]} |-> irq_lvl_o == 2'h3)
		else $error("fixed level");
	AST_DBG: assert property (irq_req_o && irq_vec_o inside {6, 7, [9:11]} |-> irq_lvl_o != 0)
		else $error("debug level");
	AST_PER: assert property (irq_req_o && irq_vec_o inside {[17:80]} |-> irq_lvl_o != 3)
		else $error("peripheral level");
endmodule // ipv_props
bind ipv_interrupt_priority_vectoring ipv_props u_props (.*);

// ### ipv_core_model.sv
// Purpose: Core side taking presented vectors
// Assumes: Wait count set by the bench while idle
// Notes: Ack is a one-cycle pulse
`timescale 1ns/1ps
module ipv_core_model (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire irq_req_i,
	input wire [1:0] wait_i,
	output reg core_ack_o
);
	reg [1:0] cnt_q;
	// Slow acks make the held vector visible for several cycles
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= 2'h0;
			core_ack_o <= 1'b0;
		end else begin
			core_ack_o <= irq_req_i && !core_ack_o && cnt_q == wait_i;
			cnt_q <= (irq_req_i && !core_ack_o) ? cnt_q + 2'h1 : 2'h0;
		end
	end
endmodule // ipv_core_model

// ### tb_interrupt_priority_vectoring.sv
// Purpose: Random arbitration trials against a reference order
// Assumes: Requests held until served
// Notes: The monitor clears each served request
`timescale 1ns/1ps
module tb_interrupt_priority_vectoring;
	logic clk = 0, rst_n = 0, we = 0, ext = 0, nar = 0;
	logic [81:0] pend = 0, en = 0;
	logic [163:0] lvl = 0;
	logic [1:0] mask = 0, wt = 0;
	logic [15:0] base = 0;
	wire ack, req, ovl;
	wire [6:0] vec;
	wire [1:0] lv;
	wire [23:0] addr;
	wire [15:0] vbr;
	logic [32:0] q[$];
	int error_cnt = 0, n_compared = 0;
	ipv_interrupt_priority_vectoring dut (.clk_sys_i(clk), .reset_n_i(rst_n), .irq_pend_i(pend),
		.irq_enable_i(en), .irq_level_i(lvl), .core_mask_lvl_i(mask), .core_ack_i(ack),
		.vector_base_register_we_i(we), .vector_base_register_wdata_i(base), .ext_boot_i(ext),
		.narrow_bus_i(nar), .irq_req_o(req), .irq_vec_o(vec), .irq_lvl_o(lv),
		.irq_addr_o(addr), .vector_base_register_o(vbr), .reset_overlay_o(ovl));
	ipv_core_model core (.clk_sys_i(clk), .reset_n_i(rst_n), .irq_req_i(req), .wait_i(wt),
		.core_ack_o(ack));
	task chk(logic [32:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function automatic int eff(int v);
		logic [1:0] p = lvl[2*v+:2];
		if (v inside {[2:5]}) return 3;
		if (v inside {[14:16]}) return 16 - v;
		if (v == 81) return 0;
		if (v inside {6, 7, [9:11]}) return p == 0 ? 1 : p;
		return p == 3 ? 2 : p;
	endfunction
	task trial;
		int v, best;
		logic [81:0] left;
		base = ($urandom % 3 == 0) ? 16'h0200 : ($urandom % 2) ? 16'($urandom) : 16'h0000;
		{ext, nar, mask, wt} = 6'($urandom);
		we = 1;
		@(negedge clk) we = 0;
		chk({vbr, ovl}, {base, base == 16'h0200 || (base == 0 && ext && nar)});
		pend = 82'({$urandom, $urandom, $urandom});
		en = 82'({$urandom, $urandom, $urandom});
		lvl = 164'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
		left = pend & en;
		do begin
			best = -1;
			for (v = 81; v >= 0; v--)
				if (left[v] && !(v inside {0, 1, 8, 12, 13, 19, 25, 36, 37, 44, 51, 70}) &&
					eff(v) >= mask && (best < 0 || eff(v) >= eff(best))) best = v;
			if (best >= 0) begin
				q.push_back({7'(best), 2'(eff(best)), {1'b0, base, 7'h00} + 24'(2 * best)});
				left[best] = 0;
			end
		end while (best >= 0);
		for (v = 0; v < 3000 && q.size() > 0; v++) @(negedge clk);
		chk(33'(q.size()), 0);
		pend = 0;
		repeat (3) @(negedge clk);
	endtask
	always @(posedge clk) begin : mon
		logic [6:0] s;
		if (req && ack) begin
			s = vec;
			chk(33'(vec < 7'h02), 0);
			if (q.size() == 0) chk(1, 0);
			else chk({vec, lv, addr}, q.pop_front());
			@(negedge clk) pend[s] = 0;
		end
	end
	initial forever #2 clk = ~clk;
	initial begin
		#(4 * 60000);
		error_cnt++;
		end_of_test;
	end
	initial begin
		void'($urandom(32'hd3e9));
		repeat (4) @(negedge clk);
		chk({req, vbr, ovl}, {1'b0, 16'h0200, 1'b1});
		rst_n = 1;
		repeat (40) trial;
		end_of_test;
	end
endmodule // tb_interrupt_priority_vectoring
